// ===== hw/io_port_change.sv
// Eight-bit I/O port with change watch, external interrupt pin and AHB-Lite registers
//
// Our own choice: the AHB-Lite interface to the registers.
`include "io_port_defs.svh"

module io_port_change
	import io_port_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hwdata_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// Port pins
	input  wire logic [7:0]  pins_i,
	output logic      [7:0]  port_out_o,
	output logic      [7:0]  port_oe_o,
	output logic      [7:0]  pullup_en_o,
	output logic      [7:0]  schmitt_sel_o,
	// Event and mode outputs
	output logic             change_flag_o,
	output logic             ext_irq_flag_o,
	output logic             halted_o,
	output logic             wake_o,
	output logic             prog_clk_o,
	output logic             prog_data_o
);

	// ============================================================
	// Pin synchroniser and instruction-cycle sampling
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic [7:0] pin_smp;
	logic [7:0] next_pin_smp;
	logic [1:0] div_cnt;
	logic [1:0] next_div_cnt;
	logic       tcy_en;

	assign tcy_en = (div_cnt == 2'(`TCY_CYCLES - 1));

	always_comb begin
		next_div_cnt = tcy_en ? 2'h0 : div_cnt + 2'h1;
		next_pin_smp = tcy_en ? pin_sync : pin_smp; // see R22, R05
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
			pin_smp  <= 8'h00;
			div_cnt  <= 2'h0;
		end else begin
			pin_meta <= pins_i;
			pin_sync <= pin_meta;
			pin_smp  <= next_pin_smp;
			div_cnt  <= next_div_cnt;
		end
	end

	// ============================================================
	// Bus decode
	function automatic logic [8:0] reg_index(input logic [31:0] addr);
		reg_index = {(addr[31:10] == 22'h0), addr[9:2]};
	endfunction

	logic [8:0] ap_dec;
	logic       ap_take;
	logic       rd_take;
	logic       rd_port;

	assign ap_dec  = reg_index(haddr_i);
	assign ap_take = hsel_i && hready_i && (htrans_i == HT_NONSEQ || htrans_i == HT_SEQ);
	assign rd_take = ap_take && !hwrite_i;
	assign rd_port = rd_take && ap_dec[8] && (ap_dec[7:0] == `PORT_IDX);

	// ============================================================
	// Port state
	data_phase_t dphase;
	data_phase_t next_dphase;
	logic [7:0]  wr_idx;
	logic [7:0]  next_wr_idx;
	logic [7:0]  latch;
	logic [7:0]  next_latch;
	logic [7:0]  drive_en;
	logic [7:0]  next_drive_en;
	logic [7:0]  option;
	logic [7:0]  next_option;
	logic [3:0]  ref_hi;
	logic [3:0]  next_ref_hi;
	logic        chg_flag;
	logic        next_chg_flag;
	logic        ext_flag;
	logic        next_ext_flag;
	logic        halted;
	logic        next_halted;
	logic        ext_en;
	logic        next_ext_en;
	logic        prog_mode;
	logic        next_prog_mode;
	logic        pin0_prev;
	logic        next_pin0_prev;
	logic        next_wake;
	logic [31:0] next_hrdata;
	logic        mism;
	logic        ext_edge;
	logic        wr_now;

	// Outputs pins are excluded from the comparison
	assign mism     = |((pin_smp[7:4] ^ ref_hi) & ~drive_en[7:4]); // see R06, R19
	assign ext_edge = ext_en && (pin_smp[0] != pin0_prev)
		&& (pin_smp[0] == option[`EDGE_BIT]); // see R07
	assign wr_now   = (dphase == DP_WRITE);

	always_comb begin
		next_dphase    = (ap_take && hwrite_i && ap_dec[8]) ? DP_WRITE : DP_IDLE;
		next_wr_idx    = ap_dec[7:0];
		next_latch     = latch;
		next_drive_en  = drive_en;
		next_option    = option;
		next_ref_hi    = ref_hi;
		next_halted    = halted;
		next_ext_en    = ext_en;
		next_prog_mode = prog_mode;
		next_pin0_prev = tcy_en ? pin_smp[0] : pin0_prev;
		next_chg_flag  = chg_flag;
		next_ext_flag  = ext_flag;
		next_wake      = 1'b0;
		next_hrdata    = 32'h0;
		// Reads return pins sampled at the start of the cycle
		if (rd_take && ap_dec[8]) begin
			if (ap_dec[7:0] == `PORT_IDX) begin
				next_hrdata = {24'h0, pin_smp}; // see R14, R15
				next_ref_hi = pin_smp[7:4]; // see R02
			end else if (ap_dec[7:0] == `OPT_IDX) begin
				next_hrdata = {24'h0, option};
			end else if (ap_dec[7:0] == `DIR_IDX) begin
				next_hrdata = {24'h0, ~drive_en};
			end else if (ap_dec[7:0] == `STAT_IDX) begin
				next_hrdata = {28'h0, mism, halted, ext_flag, chg_flag};
			end else if (ap_dec[7:0] == `CTRL_IDX) begin
				next_hrdata = {29'h0, prog_mode, ext_en, halted};
			end
		end
		// Writes land at the end of the data phase
		if (wr_now) begin
			case (wr_idx)
				`PORT_IDX: begin
					next_latch  = hwdata_i[7:0]; // see R11, R14
					next_ref_hi = pin_smp[7:4]; // see R02
				end
				`BITOP_IDX: begin
					next_latch = pin_smp; // see R12, R13
					next_latch[hwdata_i[2:0]] = hwdata_i[3];
					next_ref_hi = pin_smp[7:4];
				end
				`OPT_IDX: next_option = hwdata_i[7:0];
				`DIR_IDX: next_drive_en = ~hwdata_i[7:0]; // see R18
				`CTRL_IDX: begin
					next_halted    = halted | hwdata_i[`CT_HALT_BIT];
					next_ext_en    = hwdata_i[`CT_EXT_BIT];
					next_prog_mode = hwdata_i[`CT_PROG_BIT];
				end
				default: ;
			endcase
		end
		// Clear first so that a persisting mismatch sets the flag again
		if (wr_now && wr_idx == `STAT_IDX && hwdata_i[`ST_CHG_BIT]) begin
			next_chg_flag = 1'b0;
		end
		if (wr_now && wr_idx == `STAT_IDX && hwdata_i[`ST_EXT_BIT]) begin
			next_ext_flag = 1'b0;
		end
		if (mism) begin
			next_chg_flag = 1'b1; // see R03
		end
		if (ext_edge && tcy_en) begin
			next_ext_flag = 1'b1;
		end
		if (halted && chg_flag) begin
			next_halted = 1'b0; // see R01
			next_wake   = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			dphase        <= DP_IDLE;
			wr_idx        <= 8'h00;
			latch         <= `LATCH_RESET;
			drive_en      <= ~`DIR_RESET;
			option        <= `OPT_RESET;
			ref_hi        <= 4'h0;
			chg_flag      <= 1'b0;
			ext_flag      <= 1'b0;
			halted        <= 1'b0;
			ext_en        <= 1'b0;
			prog_mode     <= 1'b0;
			pin0_prev     <= 1'b0;
			wake_o        <= 1'b0;
			hrdata_o      <= 32'h0;
			hreadyout_o   <= 1'b0;
			hresp_o       <= 1'b0;
			pullup_en_o   <= 8'h00;
			schmitt_sel_o <= 8'h00;
			prog_clk_o    <= 1'b0;
			prog_data_o   <= 1'b0;
		end else begin
			dphase        <= next_dphase;
			wr_idx        <= next_wr_idx;
			latch         <= next_latch;
			drive_en      <= next_drive_en;
			option        <= next_option;
			ref_hi        <= next_ref_hi;
			chg_flag      <= next_chg_flag;
			ext_flag      <= next_ext_flag;
			halted        <= next_halted;
			ext_en        <= next_ext_en;
			prog_mode     <= next_prog_mode;
			pin0_prev     <= next_pin0_prev;
			wake_o        <= next_wake;
			hrdata_o      <= next_hrdata;
			hreadyout_o   <= 1'b1;
			hresp_o       <= 1'b0;
			// Pull-ups only on input pins, one cycle behind the controls
			pullup_en_o   <= option[`PU_DIS_BIT] ? 8'h00 : ~drive_en; // see R10, R20, R21
			schmitt_sel_o <= {prog_mode, prog_mode, 5'h00, ext_en}; // see R08, R09
			prog_clk_o    <= prog_mode & pin_smp[6]; // see R09
			prog_data_o   <= prog_mode & pin_smp[7];
		end
	end

	assign port_out_o     = latch;
	assign port_oe_o      = drive_en;
	assign change_flag_o  = chg_flag;
	assign ext_irq_flag_o = ext_flag;
	assign halted_o       = halted;

	// ============================================================
	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	mism_sets_flag_a: assert property (mism |=> chg_flag) // see R03
		else $error("Mismatch did not set the change flag");
	read_ends_mism_a: assert property (rd_port && !tcy_en |=> !mism) // see R02
		else $error("Port read left a mismatch");
	outputs_excluded_a: assert property (drive_en[7:4] == 4'hF |-> !mism) // see R19
		else $error("Output pins took part in the mismatch");
	wake_on_change_a: assert property (halted && chg_flag |=> !halted && wake_o) // see R01
		else $error("Change flag did not wake the halted block");
	dir_drives_pin_a: assert property (wr_now && wr_idx == `DIR_IDX // see R18
		|=> port_oe_o == ~$past(hwdata_i[7:0]))
		else $error("Direction write did not steer the drivers");
	pullup_gate_a: assert property (##1 pullup_en_o == ($past(option[7]) ? 8'h00 // see R21
		: ~$past(drive_en)))
		else $error("Pull-up enable wrong for direction or control");
	sample_rate_a: assert property (!tcy_en |=> $stable(pin_smp)) // see R22
		else $error("Pins sampled outside the instruction cycle");
	bitop_copies_a: assert property (wr_now && wr_idx == `BITOP_IDX |=> (port_out_o // see R12
		& ~(8'h01 << $past(hwdata_i[2:0]))) == ($past(pin_smp)
		& ~(8'h01 << $past(hwdata_i[2:0]))))
		else $error("Bit operation did not copy pin levels");
	read_pins_a: assert property (rd_port |=> hrdata_o[7:0] == $past(pin_smp)) // see R14
		else $error("Port read did not return the pins");
	low_pins_quiet_a: assert property ($stable(pin_smp[7:4]) && $stable(ref_hi) // see R06
		&& $stable(drive_en[7:4]) && !$past(mism) |-> !mism)
		else $error("Lower pins raised a mismatch");
	write_latch_a: assert property (wr_now && wr_idx == `PORT_IDX // see R11
		|=> port_out_o == $past(hwdata_i[7:0]))
		else $error("Port write did not reach the latch");
	write_ends_mism_a: assert property (wr_now && wr_idx == `PORT_IDX && !tcy_en // see R02
		|=> !mism)
		else $error("Port write left a mismatch");
	clear_after_end_a: assert property (wr_now && wr_idx == `STAT_IDX // see R03
		&& hwdata_i[`ST_CHG_BIT] && !mism |=> !chg_flag)
		else $error("Change flag clear was lost");
	ext_edge_flag_a: assert property (ext_edge && tcy_en |=> ext_flag) // see R07
		else $error("Pin zero edge did not set its flag");
	schmitt_pin_zero_a: assert property (##1 schmitt_sel_o[5:0] == {5'h00, $past(ext_en)}) // see R08
		else $error("Pin zero buffer select wrong");
	prog_pins_a: assert property (##1 {prog_data_o, prog_clk_o} // see R09
		== ($past(prog_mode) ? $past(pin_smp[7:6]) : 2'h0))
		else $error("Programming pins not passed through");
	halt_holds_a: assert property (halted && !chg_flag |=> halted) // see R01
		else $error("Halt ended without a port change");
	wake_single_a: assert property (wake_o |=> !wake_o) // see R01
		else $error("Wake pulse longer than one cycle");
	option_write_a: assert property (wr_now && wr_idx == `OPT_IDX // see R20
		|=> option == $past(hwdata_i[7:0]))
		else $error("Option write did not land");
	bitop_value_a: assert property (wr_now && wr_idx == `BITOP_IDX // see R12
		|=> port_out_o[$past(hwdata_i[2:0])] == $past(hwdata_i[3]))
		else $error("Bit operation lost the chosen bit");

endmodule

// ===== hw/io_port_defs.svh
// Constants for the change-watch I/O port: register indices, reset values, timing
//
// Operation
// R01: Port change interrupt wakes the block from the low-power halt state.
// R02: Any read or write of the second I/O port ends the mismatch.
// R03: Change flag keeps setting while mismatch persists; clearing works only afterwards.
// R04: Software reads the port first, then clears the change flag.
// R05: A watched pin change must last at least one instruction cycle.
// R06: Only pins four to seven take part in change detection.
// R07: Pin zero is general I/O and also the external interrupt input.
// R08: Pin zero uses Schmitt input as external interrupt, TTL otherwise.
// R09: In programming mode pin six is clock, pin seven data, Schmitt inputs.
// R10: Every port pin has a software-enabled weak pull-up.
// R11: Each port write reads the register, modifies, then writes back.
// R12: Bit set or clear copies all present pin levels into the latches.
// R13: Input pins hold unpredictable latch values after read-modify-write.
// R14: Port read returns pin levels; port write updates only the latches.
// R15: Writes land at cycle end; reads sample pins at cycle start.
// R16: Software separates a port write and a read of the port.
// R17: Software avoids polling the port while using change interrupts.
// R18: Direction one tristates the driver; zero drives the latch onto the pin.
// R19: Watched input pins compared to last-read values; mismatches ORed into flag.
// R20: Clearing option bit seven enables all pull-ups; disabled after reset.
// R21: Pull-up of any output pin is switched off automatically.
// R22: Watched pins sampled once per instruction cycle before comparison.
`ifndef IO_PORT_DEFS_SVH
`define IO_PORT_DEFS_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define PORT_IDX     8'h06
`define OPT_IDX      8'h81
`define DIR_IDX      8'h86
`define STAT_IDX     8'h10
`define CTRL_IDX     8'h11
`define BITOP_IDX    8'h12

// ============================================================
// Reset values and field positions
`define OPT_RESET    8'hFF
`define DIR_RESET    8'hFF
`define LATCH_RESET  8'h00
`define PU_DIS_BIT   7
`define EDGE_BIT     6
`define ST_CHG_BIT   0
`define ST_EXT_BIT   1
`define CT_HALT_BIT  0
`define CT_EXT_BIT   1
`define CT_PROG_BIT  2

// ============================================================
// Timing
`define OSC_NS       10
`define TCY_NS       40
`define TCY_CYCLES   ((`TCY_NS + `OSC_NS - 1) / `OSC_NS)

`endif

// ===== hw/io_port_pkg.sv
// Types for the change-watch I/O port
package io_port_pkg;

	typedef enum logic [1:0] {
		HT_IDLE,
		HT_BUSY,
		HT_NONSEQ,
		HT_SEQ
	} htrans_t;

	typedef enum {
		DP_IDLE,
		DP_WRITE
	} data_phase_t;

endpackage

// ===== tb/pin_board.sv
// Board-side model of the eight port pins
module pin_board (
	// Clock
	input  wire logic       sys_clk_i,
	// Device side
	input  wire logic [7:0] port_out_i,
	input  wire logic [7:0] port_oe_i,
	input  wire logic [7:0] pullup_en_i,
	// Board drivers
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] ext_val_i,
	// Resolved pin levels
	output logic      [7:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] flt = 8'h00;

	// A pin nobody drives or pulls changes every cycle, so no stale level is trusted
	always @(posedge sys_clk_i) begin
		flt <= ~flt;
	end

	// Board never fights an enabled device driver; a board level holds until changed
	assign pins_o = (port_oe_i & port_out_i) | (~port_oe_i & ext_en_i & ext_val_i)
		| (~port_oe_i & ~ext_en_i & pullup_en_i)
		| (~port_oe_i & ~ext_en_i & ~pullup_en_i & flt);
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the change-watch I/O port
`include "io_port_defs.svh"

module testbench import io_port_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// ====================
	// Signals
	logic        sys_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hready, hresp, chg, extf, halted, wake, pclk, pdat;
	logic [7:0]  pins, pout, poe, pup, schm;
	logic [7:0]  ext_en = 8'hF0;
	logic [7:0]  ext_val = 8'h50;
	int          fails = 0;
	int          n_tests = 0;

	localparam logic [31:0] A_PORT = {22'h0, `PORT_IDX, 2'h0};
	localparam logic [31:0] A_OPT = {22'h0, `OPT_IDX, 2'h0};
	localparam logic [31:0] A_DIR = {22'h0, `DIR_IDX, 2'h0};
	localparam logic [31:0] A_STAT = {22'h0, `STAT_IDX, 2'h0};
	localparam logic [31:0] A_CTRL = {22'h0, `CTRL_IDX, 2'h0};
	localparam logic [31:0] A_BITOP = {22'h0, `BITOP_IDX, 2'h0};

	always #5 sys_clk_i = ~sys_clk_i;

	io_port_change i_dut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
		.hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.pins_i(pins), .port_out_o(pout), .port_oe_o(poe), .pullup_en_o(pup),
		.schmitt_sel_o(schm), .change_flag_o(chg), .ext_irq_flag_o(extf),
		.halted_o(halted), .wake_o(wake), .prog_clk_o(pclk), .prog_data_o(pdat)
	);

	pin_board i_board (
		.sys_clk_i(sys_clk_i), .port_out_i(pout), .port_oe_i(poe), .pullup_en_i(pup),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .pins_o(pins)
	);

	// ====================
	// Tasks
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic wait_hi(input string nm, ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 60) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk(nm, 32'h1, 32'(s));
		if (s !== 1'b1) begin
			wrap_up();
		end
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		haddr <= a;
		hwrite <= wr;
		htrans <= HT_NONSEQ;
		hsel <= 1'b1;
		@(posedge sys_clk_i);
		wait_hi("ready", hready);
		htrans <= HT_IDLE;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge sys_clk_i);
		wait_hi("ready", hready);
		rd = hrdata;
	endtask

	task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, exp, rd);
		chk("resp", 32'h0, 32'(hresp));
	endtask

	task automatic settle();
		repeat (8) @(posedge sys_clk_i);
	endtask

	// ====================
	// Sequence
	initial begin
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(posedge sys_clk_i);
		chk("oe", 32'h0, 32'(poe));
		chk("pull", 32'h0, 32'(pup));
		rd_chk("opt", A_OPT, 32'hFF);
		rd_chk("dir", A_DIR, 32'hFF);
		rd_chk("unmapped", 32'h3FC, 32'h0);
		bus(1'b1, A_OPT, 32'h7F);
		settle();
		chk("pull", 32'hFF, 32'(pup));
		bus(1'b1, A_DIR, 32'hF0);
		bus(1'b1, A_PORT, 32'hA5);
		settle();
		chk("latch", 32'hA5, 32'(pout));
		chk("oe", 32'h0F, 32'(poe));
		chk("pull", 32'hF0, 32'(pup));
		rd_chk("port", A_PORT, 32'h55);
		bus(1'b1, A_BITOP, 32'h09);
		settle();
		chk("bitop", 32'h57, 32'(pout));
		bus(1'b1, A_DIR, 32'hFF);
		bus(1'b1, A_STAT, 32'h01);
		settle();
		chk("low", 32'h0, 32'(chg));
		ext_val <= 8'h70;
		wait_hi("chg", chg);
		rd_chk("stat", A_STAT, 32'h09);
		bus(1'b1, A_STAT, 32'h01);
		settle();
		chk("keep", 32'h1, 32'(chg));
		rd_chk("port", A_PORT, 32'h7F);
		bus(1'b1, A_STAT, 32'h01);
		settle();
		chk("clear", 32'h0, 32'(chg));
		bus(1'b1, A_CTRL, 32'h01);
		settle();
		chk("halt", 32'h1, 32'(halted));
		ext_val <= 8'hF0;
		wait_hi("wake", wake);
		settle();
		chk("run", 32'h0, 32'(halted));
		rd_chk("port", A_PORT, 32'hFF);
		bus(1'b1, A_STAT, 32'h01);
		ext_en <= 8'hF1;
		bus(1'b1, A_CTRL, 32'h02);
		settle();
		chk("st0", 32'h01, 32'(schm));
		chk("fall", 32'h0, 32'(extf));
		ext_val <= 8'hF1;
		wait_hi("int", extf);
		bus(1'b1, A_STAT, 32'h02);
		bus(1'b1, A_OPT, 32'h3F);
		settle();
		chk("extclr", 32'h0, 32'(extf));
		ext_val <= 8'hF0;
		wait_hi("fallint", extf);
		bus(1'b1, A_CTRL, 32'h04);
		settle();
		chk("st67", 32'hC0, 32'(schm));
		for (int i = 0; i < 2; i++) begin
			ext_val <= (i == 0) ? 8'hF1 : 8'h31;
			settle();
			chk("pclk", 32'(ext_val[6]), 32'(pclk));
			chk("pdat", 32'(ext_val[7]), 32'(pdat));
		end
		bus(1'b1, A_DIR, 32'h0F);
		bus(1'b1, A_STAT, 32'h01);
		settle();
		chk("masked", 32'h0, 32'(chg));
		wrap_up();
	end
endmodule
